//--- rtl/usmc_mode_control.sv
// Mode-control slice of a serial transceiver: two control registers on APB
// and the mode, flow-control, clock-pin and break logic they steer.
// Assumes frame shifting and baud ticks come from logic on CORE_CLK;
// RX_PIN and CTS_N_PIN arrive from outside and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "usmc_map.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Mute mode: node address match wakes, mismatch mutes
// - Break is ten or eleven low bit times
// - Break flag with enable raises interrupt
// - Last data bit pulse shown or suppressed
// - Phase picks first or second sampling edge
// - Polarity sets clock pin idle level
// - Clock pin driven only when enabled
// - Stop field selects one, half, two, one-half
// - LIN functions only while LIN enabled
// - Error flags interrupt with enable and receive DMA
// - Infrared coding only while infrared enabled
// - Low-power select picks infrared pulse timing
// - Half-duplex single wire when enabled
// - Card parity error sends NACK if enabled
// - Card protocol only while card enabled
// - DMA requests gated by their enables
// - Request-to-send low only while room
// - Clear-to-send low needed to start frame
// - Data written under high clear-to-send waits
// - Clear-to-send change flag with enable interrupts
// - Reduced instance drops sync, stop, card, DMA, flow bits
module usmc_mode_control #(
  parameter bit FULL_FEATURE = 1'b1
) (
  input  wire logic                     CORE_CLK,
  input  wire logic                     SYS_RST,
  input  wire logic                     CLK_EN,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire usmc_pkg::usmc_addr_type  PADDR,
  input  wire usmc_pkg::usmc_word_type  PWDATA,
  output var  usmc_pkg::usmc_word_type  PRDATA,
  output var  logic                     PREADY,
  output var  logic                     PSLVERR,
  input  wire logic                     RX_PIN,
  input  wire logic                     CTS_N_PIN,
  output var  logic                     RTS_N_PIN,
  output var  logic                     SCLK_PIN,
  output var  logic                     SCLK_OE,
  input  wire logic                     BAUD_TICK,
  input  wire logic                     MUTE_MODE,
  input  wire logic                     ADDR_TAG_VALID,
  input  wire usmc_pkg::usmc_nibble_type ADDR_TAG,
  output var  logic                     MUTED,
  input  wire logic                     LIN_FLAG_CLR,
  output var  logic                     LIN_BREAK_FLAG,
  input  wire logic                     FRAMING_ERR,
  input  wire logic                     OVERRUN_ERR,
  input  wire logic                     NOISE_ERR,
  input  wire logic                     CTS_FLAG_CLR,
  output var  logic                     CTS_CHANGE_FLAG,
  output var  logic                     IRQ,
  input  wire logic                     TX_DATA_BIT,
  input  wire logic                     TX_LAST_BIT,
  input  wire logic                     BIT_SECOND_HALF,
  output var  logic                     SAMPLE_SECOND_EDGE,
  output var  usmc_pkg::usmc_stop_type  STOP_SEL,
  output var  logic                     LIN_EN,
  output var  logic                     IRDA_EN,
  output var  logic                     IRDA_LOW_POWER,
  output var  logic                     HALF_DUPLEX,
  output var  logic                     CARD_EN,
  input  wire logic                     CARD_PARITY_ERR,
  output var  logic                     CARD_NACK_REQ,
  input  wire logic                     RX_DATA_READY,
  input  wire logic                     TX_BUF_EMPTY,
  output var  logic                     RX_DMA_REQ,
  output var  logic                     TX_DMA_REQ,
  input  wire logic                     RX_ROOM,
  input  wire logic                     TX_PENDING,
  input  wire logic                     TX_BUSY,
  output var  logic                     TX_START
);
  import usmc_pkg::*;

  localparam usmc_word_type MSK_TWO   = FULL_FEATURE ? `USMC_MSK_TWO_FULL : `USMC_MSK_TWO_LITE;
  localparam usmc_word_type MSK_THREE = FULL_FEATURE ? `USMC_MSK_THREE_FULL : `USMC_MSK_THREE_LITE;

  usmc_word_type ctrl_two_ff;
  usmc_word_type ctrl_three_ff;
  usmc_word_type prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic          rx_meta_ff, rx_sync_ff;
  logic          cts_meta_ff, cts_sync_ff, cts_prev_ff;
  logic [3:0]    low_run_ff;
  logic          break_armed_ff;
  logic          lin_flag_ff;
  logic          cts_flag_ff;
  logic          muted_ff;
  logic          irq_ff;
  logic          sclk_ff, sclk_oe_ff;
  logic          rts_n_ff;
  logic          tx_start_ff;
  logic          rx_dma_ff, tx_dma_ff;
  logic          nack_ff;
  logic [8:0]    mode_ff;
  logic          access_ok;
  logic [3:0]    break_len;
  logic          break_hit;
  logic          cts_change;
  logic          err_any;
  logic          nxt_sclk;
  logic          tx_allowed;

  // One-hot select of the two registers, shared by read and write
  function automatic logic [1:0] reg_sel(input usmc_addr_type a);
    reg_sel = {a == `USMC_OFS_CTRL_THREE, a == `USMC_OFS_CTRL_TWO};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave: answer in the cycle after setup, so access lasts one cycle
  assign access_ok = PSEL & PENABLE & pready_ff;

  // Ready, read data and error are set up during setup phase
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      pready_ff  <= PSEL & ~PENABLE;
      pslverr_ff <= PSEL & ~PENABLE & (reg_sel(PADDR) == 2'b00);
      if (PSEL & ~PENABLE & ~PWRITE) begin
        unique case (reg_sel(PADDR))
          2'b01:   prdata_ff <= ctrl_two_ff;
          2'b10:   prdata_ff <= ctrl_three_ff;
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes; masked bits stay zero in both instances
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_two_ff   <= `USMC_RST_CTRL_TWO;
      ctrl_three_ff <= `USMC_RST_CTRL_THREE;
    end else if (CLK_EN && access_ok && PWRITE) begin
      if (reg_sel(PADDR) == 2'b01) begin
        ctrl_two_ff <= PWDATA & MSK_TWO;
      end
      if (reg_sel(PADDR) == 2'b10) begin
        ctrl_three_ff <= PWDATA & MSK_THREE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rx_meta_ff  <= 1'b1;
      rx_sync_ff  <= 1'b1;
      cts_meta_ff <= 1'b1;
      cts_sync_ff <= 1'b1;
      cts_prev_ff <= 1'b1;
    end else if (CLK_EN) begin
      rx_meta_ff  <= RX_PIN;
      rx_sync_ff  <= rx_meta_ff;
      cts_meta_ff <= CTS_N_PIN;
      cts_sync_ff <= cts_meta_ff;
      cts_prev_ff <= cts_sync_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Break detection: count low bit times, fire once per low period
  assign break_len = ctrl_two_ff[`USMC_LIN_LEN_BIT] ? `USMC_BREAK_LONG : `USMC_BREAK_SHORT;
  assign break_hit = ctrl_two_ff[`USMC_LIN_EN_BIT] & ~rx_sync_ff & BAUD_TICK & break_armed_ff
                     & (low_run_ff == break_len - 4'h1);

  // Run counter cleared by any high level or with LIN off
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      low_run_ff     <= 4'h0;
      break_armed_ff <= 1'b1;
    end else if (CLK_EN) begin
      if (rx_sync_ff || !ctrl_two_ff[`USMC_LIN_EN_BIT]) begin
        low_run_ff     <= 4'h0;
        break_armed_ff <= 1'b1;
      end else if (BAUD_TICK && break_armed_ff) begin
        low_run_ff <= low_run_ff + 4'h1;
        if (break_hit) begin
          break_armed_ff <= 1'b0;
        end
      end
    end
  end

  // Sticky break flag; a new break beats a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lin_flag_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (break_hit) begin
        lin_flag_ff <= 1'b1;
      end else if (LIN_FLAG_CLR) begin
        lin_flag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear-to-send change flag, same set-wins ordering
  assign cts_change = ctrl_three_ff[`USMC_CTS_BIT] & (cts_sync_ff != cts_prev_ff);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cts_flag_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (cts_change) begin
        cts_flag_ff <= 1'b1;
      end else if (CTS_FLAG_CLR) begin
        cts_flag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request combines the three enabled sources
  assign err_any = FRAMING_ERR | OVERRUN_ERR | NOISE_ERR;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_ff <= 1'b0;
    end else if (CLK_EN) begin
      irq_ff <= (lin_flag_ff & ctrl_two_ff[`USMC_LIN_IRQ_BIT])
              | (err_any & ctrl_three_ff[`USMC_ERR_IRQ_BIT] & ctrl_three_ff[`USMC_RX_DMA_BIT])
              | (cts_flag_ff & ctrl_three_ff[`USMC_CTS_IRQ_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Multiprocessor mute: tag compare decides mute or wake
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      muted_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (!MUTE_MODE) begin
        muted_ff <= 1'b0;
      end else if (ADDR_TAG_VALID) begin
        muted_ff <= ADDR_TAG != ctrl_two_ff[`USMC_NODE_ADDR_MSB:`USMC_NODE_ADDR_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial clock pin: idle at polarity, one pulse per data bit; last bit's pulse only with its bit set.
  // Phase 0 toggles mid-bit so the first edge samples; phase 1 leads.
  // Clock bits are taken live: changing them mid-frame glitches the pin.
  always_comb begin
    nxt_sclk = ctrl_two_ff[`USMC_POLARITY_BIT];
    if (TX_DATA_BIT && !(TX_LAST_BIT && !ctrl_two_ff[`USMC_LAST_PULSE_BIT])) begin
      nxt_sclk = ctrl_two_ff[`USMC_POLARITY_BIT]
               ^ (ctrl_two_ff[`USMC_PHASE_BIT] ? ~BIT_SECOND_HALF : BIT_SECOND_HALF);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sclk_ff    <= 1'b0;
      sclk_oe_ff <= 1'b0;
    end else if (CLK_EN) begin
      sclk_ff    <= nxt_sclk;
      sclk_oe_ff <= ctrl_two_ff[`USMC_CLK_PIN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode levels for the frame logic, registered for clean outputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_ff <= 9'h000;
    end else if (CLK_EN) begin
      mode_ff <= {ctrl_two_ff[`USMC_PHASE_BIT],
                  ctrl_two_ff[`USMC_STOP_MSB:`USMC_STOP_LSB],
                  ctrl_two_ff[`USMC_LIN_EN_BIT],
                  ctrl_three_ff[`USMC_IR_EN_BIT],
                  ctrl_three_ff[`USMC_IR_EN_BIT] & ctrl_three_ff[`USMC_IR_LP_BIT],
                  ctrl_three_ff[`USMC_HDX_BIT],
                  ctrl_three_ff[`USMC_CARD_BIT],
                  1'b0};
    end
  end

  // Card NACK on parity error, only with card mode and NACK on
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      nack_ff <= 1'b0;
    end else if (CLK_EN) begin
      nack_ff <= CARD_PARITY_ERR & ctrl_three_ff[`USMC_CARD_BIT]
               & ctrl_three_ff[`USMC_NACK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // DMA requests follow their sources only while enabled
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rx_dma_ff <= 1'b0;
      tx_dma_ff <= 1'b0;
    end else if (CLK_EN) begin
      rx_dma_ff <= RX_DATA_READY & ctrl_three_ff[`USMC_RX_DMA_BIT];
      tx_dma_ff <= TX_BUF_EMPTY & ctrl_three_ff[`USMC_TX_DMA_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flow control: request-to-send low means room; without it, always low.
  // Clear-to-send gates only frame starts, so a running frame completes
  // and written data simply stays pending until the line goes low.
  assign tx_allowed = ~ctrl_three_ff[`USMC_CTS_BIT] | ~cts_sync_ff;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rts_n_ff    <= 1'b1;
      tx_start_ff <= 1'b0;
    end else if (CLK_EN) begin
      rts_n_ff    <= ctrl_three_ff[`USMC_RTS_BIT] & ~RX_ROOM;
      tx_start_ff <= TX_PENDING & ~TX_BUSY & ~tx_start_ff & tx_allowed;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output wiring, every one from a flip-flop
  assign PRDATA             = prdata_ff;
  assign PREADY             = pready_ff;
  assign PSLVERR            = pslverr_ff;
  assign RTS_N_PIN          = rts_n_ff;
  assign SCLK_PIN           = sclk_ff;
  assign SCLK_OE            = sclk_oe_ff;
  assign MUTED              = muted_ff;
  assign LIN_BREAK_FLAG     = lin_flag_ff;
  assign CTS_CHANGE_FLAG    = cts_flag_ff;
  assign IRQ                = irq_ff;
  assign SAMPLE_SECOND_EDGE = mode_ff[8];
  assign STOP_SEL           = mode_ff[7:6];
  assign LIN_EN             = mode_ff[5];
  assign IRDA_EN            = mode_ff[4];
  assign IRDA_LOW_POWER     = mode_ff[3];
  assign HALF_DUPLEX        = mode_ff[2];
  assign CARD_EN            = mode_ff[1];
  assign CARD_NACK_REQ      = nack_ff;
  assign RX_DMA_REQ         = rx_dma_ff;
  assign TX_DMA_REQ         = tx_dma_ff;
  assign TX_START           = tx_start_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks beside the logic
  a_break_flag_set: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && break_hit |=> lin_flag_ff)
    else $error("break not flagged");

  a_break_needs_lin: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(lin_flag_ff) |-> $past(ctrl_two_ff[`USMC_LIN_EN_BIT]))
    else $error("break flagged with LIN off");

  a_break_irq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && lin_flag_ff && ctrl_two_ff[`USMC_LIN_IRQ_BIT] |=> irq_ff)
    else $error("break interrupt missing");

  a_err_irq_gate: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && err_any && !ctrl_three_ff[`USMC_RX_DMA_BIT] && !lin_flag_ff && !cts_flag_ff |=> !irq_ff)
    else $error("error interrupt without receive DMA");

  a_cts_irq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && cts_flag_ff && ctrl_three_ff[`USMC_CTS_IRQ_BIT] |=> irq_ff)
    else $error("clear-to-send interrupt missing");

  a_mute_compare: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && MUTE_MODE && ADDR_TAG_VALID
    |=> muted_ff == ($past(ADDR_TAG) != $past(ctrl_two_ff[3:0])))
    else $error("address match decision wrong");

  a_clock_oe: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN ##1 CLK_EN |-> sclk_oe_ff == $past(ctrl_two_ff[`USMC_CLK_PIN_BIT]))
    else $error("clock pin enable wrong");

  a_clock_idle: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !TX_DATA_BIT |=> sclk_ff == $past(ctrl_two_ff[`USMC_POLARITY_BIT]))
    else $error("clock idle level wrong");

  a_last_pulse: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && TX_LAST_BIT && !ctrl_two_ff[`USMC_LAST_PULSE_BIT]
    |=> sclk_ff == $past(ctrl_two_ff[`USMC_POLARITY_BIT]))
    else $error("last bit pulse not suppressed");

  a_cts_gate: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(tx_start_ff) |-> $past(!ctrl_three_ff[`USMC_CTS_BIT] || !cts_sync_ff))
    else $error("frame started under high clear-to-send");

  a_rts_level: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && ctrl_three_ff[`USMC_RTS_BIT] && RX_ROOM |=> !rts_n_ff)
    else $error("request-to-send high with room");

  a_apb_answer: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && PSEL && !PENABLE |=> pready_ff)
    else $error("APB answer late");

endmodule
`default_nettype wire

//--- rtl/usmc_map.svh
// Register offsets, field positions, reset values and counts of the mode-control slice.
// Assumes byte addresses on a 32-bit APB; included by its bare name.
`ifndef USMC_MAP_SVH
`define USMC_MAP_SVH

`define USMC_OFS_CTRL_TWO    8'h10
`define USMC_OFS_CTRL_THREE  8'h14
`define USMC_RST_CTRL_TWO    32'h0000_0000
`define USMC_RST_CTRL_THREE  32'h0000_0000

// Writable bits, full and reduced asynchronous-only instance
`define USMC_MSK_TWO_FULL    32'h0000_7F6F
`define USMC_MSK_THREE_FULL  32'h0000_07FF
`define USMC_MSK_TWO_LITE    32'h0000_406F
`define USMC_MSK_THREE_LITE  32'h0000_000F

// Second control register fields
`define USMC_NODE_ADDR_LSB   0
`define USMC_NODE_ADDR_MSB   3
`define USMC_LIN_LEN_BIT     5
`define USMC_LIN_IRQ_BIT     6
`define USMC_LAST_PULSE_BIT  8
`define USMC_PHASE_BIT       9
`define USMC_POLARITY_BIT    10
`define USMC_CLK_PIN_BIT     11
`define USMC_STOP_LSB        12
`define USMC_STOP_MSB        13
`define USMC_LIN_EN_BIT      14

// Third control register fields
`define USMC_ERR_IRQ_BIT     0
`define USMC_IR_EN_BIT       1
`define USMC_IR_LP_BIT       2
`define USMC_HDX_BIT         3
`define USMC_NACK_BIT        4
`define USMC_CARD_BIT        5
`define USMC_RX_DMA_BIT      6
`define USMC_TX_DMA_BIT      7
`define USMC_RTS_BIT         8
`define USMC_CTS_BIT         9
`define USMC_CTS_IRQ_BIT     10

// Break lengths in bit times
`define USMC_BREAK_SHORT     4'hA
`define USMC_BREAK_LONG      4'hB

`endif

//--- rtl/usmc_pkg.sv
// Types shared by the mode-control slice.
// Assumes the map header carries all numbers.
package usmc_pkg;
  typedef logic [31:0] usmc_word_type;
  typedef logic [7:0]  usmc_addr_type;
  typedef logic [1:0]  usmc_stop_type;
  typedef logic [3:0]  usmc_nibble_type;
endpackage

//--- testbench/usmc_far_side.sv
// Far-side serial node: drives the receive line and the clear-to-send input.
// Assumes the bench asks for a break level and a stop-sending level.
`timescale 1ns/1ns
`default_nettype none
module usmc_far_side (
  input  wire logic hold_break,
  input  wire logic hold_off,
  output var  logic RX_PIN,
  output var  logic CTS_N_PIN
);
  logic link_clk;
  ////////////////////////////////////////////////////////////////////////////
  // Own 125 ns link clock, unrelated in phase to the core clock
  initial begin
    link_clk = 1'b0;
    RX_PIN = 1'b1;
    CTS_N_PIN = 1'b0;
    #17;
    forever begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end
  // Lines move on link edges only; an idle receive line sits high
  always @(posedge link_clk) begin
    RX_PIN <= !hold_break;
    CTS_N_PIN <= hold_off;
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the mode-control slice: APB access, mode outputs,
// break detection, flow control and address matching.
// Assumes the far-side model drives the receive and clear-to-send lines.
`timescale 1ns/1ns
`default_nettype none
`include "usmc_map.svh"
module testbench;
  import usmc_pkg::*;
  logic          clk, rst, psel, penable, pwrite, tick, mute, tag_vld, lin_clr, cts_clr, pend, brk, stop;
  logic          rx, cts_n, rts_n, sclk, sclk_oe, muted, lin_flag, cts_flag, irq, second, lin_en, start;
  logic          fe, ov, ne, dbit, lbit, half, ir_en, ir_lp, hdx, card, perr, nack, rxrdy, txe, rxdma, txdma, room;
  logic          err, e, pready, ce, busy;
  usmc_addr_type paddr;
  usmc_word_type pwdata, prdata, rd, w2, w3;
  usmc_stop_type stop_sel;
  usmc_nibble_type tag;
  logic [9:0]    r;
  int            mismatches, checks, n;

  usmc_far_side far (.hold_break(brk), .hold_off(stop), .RX_PIN(rx), .CTS_N_PIN(cts_n));

  usmc_mode_control dut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(err),
    .RX_PIN(rx), .CTS_N_PIN(cts_n), .RTS_N_PIN(rts_n), .SCLK_PIN(sclk), .SCLK_OE(sclk_oe),
    .BAUD_TICK(tick), .MUTE_MODE(mute), .ADDR_TAG_VALID(tag_vld), .ADDR_TAG(tag), .MUTED(muted),
    .LIN_FLAG_CLR(lin_clr), .LIN_BREAK_FLAG(lin_flag), .FRAMING_ERR(fe), .OVERRUN_ERR(ov),
    .NOISE_ERR(ne), .CTS_FLAG_CLR(cts_clr), .CTS_CHANGE_FLAG(cts_flag), .IRQ(irq), .TX_DATA_BIT(dbit),
    .TX_LAST_BIT(lbit), .BIT_SECOND_HALF(half), .SAMPLE_SECOND_EDGE(second), .STOP_SEL(stop_sel),
    .LIN_EN(lin_en), .IRDA_EN(ir_en), .IRDA_LOW_POWER(ir_lp), .HALF_DUPLEX(hdx), .CARD_EN(card),
    .CARD_PARITY_ERR(perr), .CARD_NACK_REQ(nack), .RX_DATA_READY(rxrdy), .TX_BUF_EMPTY(txe),
    .RX_DMA_REQ(rxdma), .TX_DMA_REQ(txdma), .RX_ROOM(room), .TX_PENDING(pend), .TX_BUSY(busy),
    .TX_START(start));

  ////////////////////////////////////////////////////////////////////////////
  // Core clock, 100 MHz
  always #5 clk = ~clk;

  task automatic end_sim();
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // One APB transfer; request held until the edge that sees ready high
  task automatic apb(input logic wr, input usmc_addr_type a, input usmc_word_type wd);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(k < 20, 1, "no ready");
    // Answer taken at the edge that sees ready high
    rd = prdata;
    e = err;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      cyc(3);
    end
  endtask

  // Mode outputs worked out from both control words and the side inputs
  function automatic logic [14:0] exp_modes(input usmc_word_type a, input usmc_word_type b, input logic [9:0] s);
    logic pin;
    pin = a[10];
    if (s[0] && !(s[1] && !a[8])) pin = a[10] ^ (a[9] ? !s[2] : s[2]);
    return {a[11], pin, a[9], a[13:12], a[14], b[1], b[1] & b[2], b[3], b[5], s[3] & b[5] & b[4],
            s[4] & b[6], s[5] & b[7], b[8] & !s[6], b[0] & b[6] & (|s[9:7])};
  endfunction

  // Watchdog against a hung handshake
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    {clk, psel, penable, pwrite, tick, mute, tag_vld, lin_clr, cts_clr, pend, brk, stop} = '0;
    {ne, ov, fe, room, txe, rxrdy, perr, half, lbit, dbit} = '0;
    {paddr, pwdata, tag, mismatches, checks} = '0;
    {e, busy} = '0;
    ce = 1'b1;
    rst = 1'b1;
    void'($urandom(85));
    cyc(3);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 8'h10 + 8'(4 * k), '0);
      chk({e, rd}, {k == 2, 32'h0000_0000}, "reset or unmapped read");
    end
    for (int i = 0; i < 24; i++) begin
      w2 = (i < 2) ? {32{i == 0}} : $urandom();
      w3 = (i < 2) ? {32{i == 0}} : $urandom();
      r = 10'($urandom());
      {ne, ov, fe, room, txe, rxrdy, perr, half, lbit, dbit} <= '0;
      apb(1'b1, `USMC_OFS_CTRL_TWO, w2); // Clock bits set while idle
      apb(1'b1, `USMC_OFS_CTRL_THREE, w3);
      {ne, ov, fe, room, txe, rxrdy, perr, half, lbit, dbit} <= r;
      cyc(3);
      chk({sclk_oe, sclk, second, stop_sel, lin_en, ir_en, ir_lp, hdx, card, nack, rxdma, txdma, rts_n, irq},
          exp_modes(w2, w3, r), "mode outputs");
      apb(1'b0, `USMC_OFS_CTRL_TWO, '0);
      chk({e, rd}, {1'b0, w2 & `USMC_MSK_TWO_FULL}, "second register");
      apb(1'b0, `USMC_OFS_CTRL_THREE, '0);
      chk({e, rd}, {1'b0, w3 & `USMC_MSK_THREE_FULL}, "third register");
    end
    {ne, ov, fe, room, txe, rxrdy, perr, half, lbit, dbit} <= '0;
    // Break one tick short, then at full length; last case with LIN off
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `USMC_OFS_CTRL_TWO, {17'h0, c < 2, 7'h0, 1'b1, c == 1, 5'h0});
      brk <= 1'b1;
      cyc(40);
      ticks(9 + (c == 1));
      chk(lin_flag, 0, "early break");
      ticks(1);
      chk({lin_flag, irq}, {2{c < 2}}, "break flag");
      brk <= 1'b0;
      cyc(40);
      lin_clr <= 1'b1;
      @(posedge clk);
      lin_clr <= 1'b0;
    end
    apb(1'b1, `USMC_OFS_CTRL_THREE, 32'h0000_0600);
    stop <= 1'b1;
    cyc(40);
    chk({cts_flag, irq}, 2'b11, "change flag");
    cts_clr <= 1'b1;
    pend <= 1'b1;
    @(posedge clk);
    cts_clr <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      chk(start, 0, "start while held off");
    end
    @(posedge clk);
    stop <= 1'b0;
    n = 0;
    while (start !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(start, 1, "held data sent");
    // Pending dropped at once so no second start follows
    pend <= 1'b0;
    @(posedge clk);
    apb(1'b1, `USMC_OFS_CTRL_TWO, 32'h0000_000A);
    mute <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      tag <= k ? 4'hA : 4'h5;
      tag_vld <= 1'b1;
      @(posedge clk);
      tag_vld <= 1'b0;
      cyc(2);
      chk(muted, k == 0, "address match");
    end
    end_sim();
  end
endmodule
`default_nettype wire
